// ==== extended_status_word.sv ====
// extended status word assembly with wishbone access and event interrupt
`timescale 1ns/100ps
// Operation
// - short averaging: general fault when no new value for ten seconds.
// - long averaging: general fault when buffer holds under half expected values.
// - bit 1 follows the heater switch-on criterion.
// - bit 2 follows the actual heater state.
// - bit 4 set when a persistent fault lasts over one minute.
// - bits 3 and 5 to 7 always read zero.
// - bits 14 to 31 always read zero.
// - bits 8 to 11 give buffer fill in sixteenths, code n above n/16.
// - restart flag clears after the first output telegram is sent.
module extended_status_word #(
	parameter int NOVAL_CYCLES = esw_pkg::NOVAL_CYC,
	parameter int STATIC_CYCLES = esw_pkg::STATIC_CYC,
	parameter int SEC_CYCLES = esw_pkg::SEC_CYC,
	parameter int BUF_DEPTH = 600
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire esw_pkg::sense_t sense_i,
	input wire logic telegram_sent_i,
	output logic [31:0] status_o,
	output logic irq_o
);
	localparam int BW = $clog2(BUF_DEPTH + 1);
	localparam int SCW = $clog2(SEC_CYCLES + 1);
	initial begin
		if (BUF_DEPTH < 2 || BUF_DEPTH > 65535) $error("BUF_DEPTH out of range");
		if (SEC_CYCLES < 1) $error("SEC_CYCLES must be positive");
	end

	esw_pkg::sense_t sense_s;
	esw_pkg::ctrl_t ctrl_ff;
	logic meas_prev_ff;
	logic meas_pulse;
	logic noval_exp;
	logic static_exp;
	logic sec_tick_ff;
	logic [SCW-1:0] sec_cnt_ff;
	logic [15:0] fill_ff;
	logic [15:0] win_ff;
	logic [BW-1:0] cap;
	logic gen_fault_ff;
	logic static_fault_ff;
	logic restart_ff;
	logic [3:0] fill_code_ff;
	logic [31:0] nxt_status;
	logic [2:0] irq_stat_ff;
	logic [2:0] irq_mask_ff;
	logic [2:0] irq_ev;
	logic [31:0] prev_status_ff;
	logic wb_req;
	logic wb_wr;
	logic stat_rd;

	// pins pass two flops before use
	sync2 #(.W($bits(esw_pkg::sense_t))) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(sense_i),
		.q_o(sense_s)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			meas_prev_ff <= 1'b0;
		else
			meas_prev_ff <= sense_s.meas_new;
	end
	assign meas_pulse = sense_s.meas_new & ~meas_prev_ff;

	timeout_cnt #(.LIMIT(NOVAL_CYCLES)) u_noval (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(meas_pulse),
		.expired_o(noval_exp)
	);

	// persistent fault timer, restarts whenever the fault lapses
	timeout_cnt #(.LIMIT(STATIC_CYCLES)) u_static (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(~(sense_s.virtual_temperature_violation | noval_exp)),
		.expired_o(static_exp)
	);

	// one-second tick paces the expected sample count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sec_cnt_ff <= '0;
			sec_tick_ff <= 1'b0;
		end else if (sec_cnt_ff == SCW'(SEC_CYCLES - 1)) begin
			sec_cnt_ff <= '0;
			sec_tick_ff <= 1'b1;
		end else begin
			sec_cnt_ff <= sec_cnt_ff + SCW'(1);
			sec_tick_ff <= 1'b0;
		end
	end

	// averaging buffer window: expected count grows to avg_sec, fill saturates there
	// simplification: fill counts samples, never ages them out
	// averaging beyond the buffer depth saturates at the depth
	assign cap = (ctrl_ff.avg_sec == 16'h0000) ? BW'(1) :
		(ctrl_ff.avg_sec > 16'(BUF_DEPTH)) ? BW'(BUF_DEPTH) : BW'(ctrl_ff.avg_sec);
	// shrinking the window trims both counts, keeps the code within 4 bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fill_ff <= 16'h0000;
			win_ff <= 16'h0000;
		end else begin
			if (fill_ff > 16'(cap))
				fill_ff <= 16'(cap);
			else if (meas_pulse && fill_ff < 16'(cap))
				fill_ff <= fill_ff + 16'h0001;
			if (win_ff > 16'(cap))
				win_ff <= 16'(cap);
			else if (sec_tick_ff && win_ff < 16'(cap))
				win_ff <= win_ff + 16'h0001;
		end
	end

	// under half of expected values counts as fault
	always_ff @(posedge clk_i) begin
		if (rst_i)
			gen_fault_ff <= 1'b0;
		else if (ctrl_ff.avg_sec < 16'(esw_pkg::AVG_SHORT_SEC))
			gen_fault_ff <= noval_exp;
		else
			gen_fault_ff <= ({fill_ff, 1'b0} < {1'b0, win_ff});
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			static_fault_ff <= 1'b0;
		else
			static_fault_ff <= static_exp;
	end

	// code n covers n/16 < fill <= (n+1)/16, i.e. ceil(16*fill/cap)-1
	always_ff @(posedge clk_i) begin
		if (rst_i)
			fill_code_ff <= 4'h0;
		else if (fill_ff == 16'h0000)
			fill_code_ff <= 4'h0;
		else
			fill_code_ff <= 4'((({fill_ff, 4'h0} + 20'(cap) - 20'h00001) / 20'(cap)) - 20'h00001);
	end

	// cleared once the first telegram has gone out
	always_ff @(posedge clk_i) begin
		if (rst_i)
			restart_ff <= 1'b1;
		else if (telegram_sent_i)
			restart_ff <= 1'b0;
	end

	always_comb begin
		nxt_status = 32'h00000000;
		nxt_status[esw_pkg::BIT_GEN_FAULT] = gen_fault_ff;
		nxt_status[esw_pkg::BIT_HEAT_CRIT] = sense_s.heat_crit;
		nxt_status[esw_pkg::BIT_HEAT_ON] = sense_s.heat_on;
		nxt_status[esw_pkg::BIT_STATIC_FAULT] = static_fault_ff;
		nxt_status[esw_pkg::FILL_MSB:esw_pkg::FILL_LSB] = fill_code_ff;
		nxt_status[esw_pkg::BIT_RESTART] = restart_ff;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			status_o <= esw_pkg::STATUS_RST;
		else
			status_o <= nxt_status;
	end

	// wishbone classic slave, ack one cycle after request
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_req & wb_we_i;
	assign stat_rd = wb_req & ~wb_we_i & (wb_adr_i == esw_pkg::ADDR_IRQ_STAT);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					esw_pkg::ADDR_STATUS: wb_dat_o <= status_o;
					esw_pkg::ADDR_CTRL: wb_dat_o <= ctrl_ff;
					esw_pkg::ADDR_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_ff};
					esw_pkg::ADDR_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask_ff};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= esw_pkg::CTRL_RST;
			irq_mask_ff <= esw_pkg::IRQ_RST;
		end else if (wb_wr) begin
			if (wb_adr_i == esw_pkg::ADDR_CTRL) begin
				if (wb_sel_i[0])
					ctrl_ff.avg_sec[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					ctrl_ff.avg_sec[15:8] <= wb_dat_i[15:8];
			end
			if (wb_adr_i == esw_pkg::ADDR_IRQ_MASK && wb_sel_i[0])
				irq_mask_ff <= wb_dat_i[2:0];
		end
	end

	// events: rise of general fault, static fault, heater on
	always_ff @(posedge clk_i) begin
		if (rst_i)
			prev_status_ff <= 32'h00000000;
		else
			prev_status_ff <= status_o;
	end
	assign irq_ev = {
		status_o[esw_pkg::BIT_HEAT_ON] & ~prev_status_ff[esw_pkg::BIT_HEAT_ON],
		status_o[esw_pkg::BIT_STATIC_FAULT] & ~prev_status_ff[esw_pkg::BIT_STATIC_FAULT],
		status_o[esw_pkg::BIT_GEN_FAULT] & ~prev_status_ff[esw_pkg::BIT_GEN_FAULT]
	};

	// set wins over the read clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_stat_ff <= esw_pkg::IRQ_RST;
		else
			irq_stat_ff <= (stat_rd ? 3'h0 : irq_stat_ff) | irq_ev;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(((stat_rd ? 3'h0 : irq_stat_ff) | irq_ev) & irq_mask_ff);
	end

	a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(status_o & 32'hFFFFD0E8) == 32'h0) else $error("reserved bit set");
	a_heat_crit: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(sense_s.heat_crit) |=> status_o[1]) else $error("heat crit late");
	a_heat_on: assert property (@(posedge clk_i) disable iff (rst_i)
		sense_s.heat_on |=> status_o[2]) else $error("heat on not shown");
	a_heat_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!sense_s.heat_on |=> !status_o[2]) else $error("heat off not shown");
	a_restart_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		telegram_sent_i |=> ##1 !status_o[13]) else $error("restart not cleared");
	a_restart_set: assert property (@(posedge clk_i)
		rst_i ##1 !rst_i |-> status_o[13]) else $error("restart not set");
	a_noval_fault: assert property (@(posedge clk_i) disable iff (rst_i)
		(noval_exp && ctrl_ff.avg_sec < 16'd10) |=> ##1 (status_o[0] ||
		$past(ctrl_ff.avg_sec) != ctrl_ff.avg_sec)) else $error("no-value fault missed");
	a_long_fault: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl_ff.avg_sec >= 16'd10 && {fill_ff, 1'b0} >= {1'b0, win_ff}) [*3]
		|-> !status_o[0]) else $error("false fault");
	a_static_fault: assert property (@(posedge clk_i) disable iff (rst_i)
		static_exp |=> ##1 status_o[4]) else $error("static fault missed");
	a_fill_full: assert property (@(posedge clk_i) disable iff (rst_i)
		(fill_ff == 16'(cap)) [*3] |-> status_o[11:8] == 4'hF) else $error("fill code wrong");
endmodule // extended_status_word

// ==== esw_pkg.sv ====
// package: constants and types for the extended status word block
package esw_pkg;
	// bit positions of the status word
	localparam int BIT_GEN_FAULT = 0;
	localparam int BIT_HEAT_CRIT = 1;
	localparam int BIT_HEAT_ON = 2;
	localparam int BIT_STATIC_FAULT = 4;
	localparam int FILL_LSB = 8;
	localparam int FILL_MSB = 11;
	localparam int BIT_RESTART = 13;
	// register byte addresses
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000000A;
	localparam logic [2:0] IRQ_RST = 3'h0;
	localparam logic [31:0] STATUS_RST = 32'h00002000;
	// timing
	localparam int CLK_HZ = 10000000;
	localparam int NOVAL_SEC = 10;
	localparam int STATIC_SEC = 60;
	localparam int AVG_SHORT_SEC = 10;
	localparam int NOVAL_CYC = NOVAL_SEC * CLK_HZ;
	localparam int STATIC_CYC = STATIC_SEC * CLK_HZ;
	localparam int SEC_CYC = CLK_HZ;
	// control register layout
	typedef struct packed {
		logic [15:0] rsvd;
		logic [15:0] avg_sec;
	} ctrl_t;
	// raw condition inputs, all from pins
	typedef struct packed {
		logic meas_new;
		logic heat_crit;
		logic heat_on;
		logic virtual_temperature_violation;
	} sense_t;
endpackage

// ==== sync2.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sync2 #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			q_o <= '0;
		end else begin
			meta_ff <= d_i;
			q_o <= meta_ff;
		end
	end
endmodule // sync2

// ==== timeout_cnt.sv ====
// saturating timer that flags once a condition has held for LIMIT cycles
`timescale 1ns/100ps
module timeout_cnt #(
	parameter int LIMIT = 100
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	output logic expired_o
);
	localparam int CW = $clog2(LIMIT + 1);
	logic [CW-1:0] cnt_ff;
	initial begin
		if (LIMIT < 1) $error("timeout_cnt: LIMIT must be at least 1");
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			cnt_ff <= '0;
			expired_o <= 1'b0;
		end else begin
			if (cnt_ff != CW'(LIMIT))
				cnt_ff <= cnt_ff + CW'(1);
			expired_o <= (cnt_ff >= CW'(LIMIT - 1));
		end
	end
endmodule // timeout_cnt

// ==== telegram_host.sv ====
// host model that takes output telegrams carrying the status word
`timescale 1ns/100ps
module telegram_host (
	input wire logic clk_i,
	input wire logic [31:0] status_i,
	output logic telegram_sent_o
);
	initial telegram_sent_o = 1'b0;
	// word taken at the edge of the one-cycle send pulse
	task automatic send(output logic [31:0] word);
		@(posedge clk_i);
		telegram_sent_o <= 1'b1;
		@(posedge clk_i);
		word = status_i;
		telegram_sent_o <= 1'b0;
	endtask
endmodule // telegram_host

// ==== tb_extended_status_word.sv ====
// self-checking bench for the extended status word block
`timescale 1ns/100ps
module tb_extended_status_word;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] wb_adr_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o, status_o, rd, tw;
	logic wb_ack_o, irq_o, tsent;
	esw_pkg::sense_t sense = '0;
	int n_errors = 0;
	int num_checks = 0;
	always #50 clk_i = ~clk_i;
	// short counts keep the run small
	extended_status_word #(.NOVAL_CYCLES(50), .STATIC_CYCLES(200), .SEC_CYCLES(10)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sense_i(sense),
		.telegram_sent_i(tsent), .status_o(status_o), .irq_o(irq_o));
	telegram_host host (.clk_i(clk_i), .status_i(status_o), .telegram_sent_o(tsent));
	task automatic final_report();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d,
			output logic [31:0] q);
		int i;
		@(posedge clk_i);
		wb_adr_i <= a;
		wb_we_i <= we;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1) break;
		end
		q = wb_dat_o;
		if (i == 20) begin
			chk(32'h0, 32'h1);
			final_report();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// bounded wait for a status bit to reach a level
	task automatic wait_bit(input int b, input logic v, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge clk_i);
			if (status_o[b] === v) break;
		end
		chk({31'h0, status_o[b]}, {31'h0, v});
		if (i == lim) final_report();
	endtask
	task automatic sample(input int n);
		repeat (n) begin
			@(posedge clk_i);
			sense.meas_new <= 1'b1;
			repeat (3) @(posedge clk_i);
			sense.meas_new <= 1'b0;
			repeat (6) @(posedge clk_i);
		end
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(status_o, 32'h00002000);
		wb(esw_pkg::ADDR_STATUS, 1'b0, 32'h0, rd);
		chk(rd, 32'h00002000);
		// unmapped places: read zero, write acked and dropped
		wb(4'h6, 1'b1, 32'hFFFFFFFF, rd);
		wb(4'h2, 1'b0, 32'h0, rd);
		chk(rd, 32'h0);
		host.send(tw);
		chk({31'h0, tw[13]}, 32'h1);
		repeat (3) @(posedge clk_i);
		chk({31'h0, status_o[13]}, 32'h0);
		host.send(tw);
		chk({31'h0, tw[13]}, 32'h0);
		wait_bit(0, 1'b1, 40);
		chk({31'h0, irq_o}, 32'h0);
		sample(5);
		repeat (5) @(posedge clk_i);
		chk({28'h0, status_o[11:8]}, 32'h7);
		sample(5);
		repeat (5) @(posedge clk_i);
		chk({28'h0, status_o[11:8]}, 32'hF);
		wait_bit(0, 1'b0, 40);
		chk(status_o & 32'hFFFFD0E8, 32'h0);
		wb(esw_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0, rd);
		// only the general fault has risen so far
		chk(rd, 32'h1);
		wb(esw_pkg::ADDR_IRQ_MASK, 1'b1, 32'h4, rd);
		sense.heat_crit <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk({30'h0, status_o[2:1]}, 32'h1);
		sense.heat_on <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk({30'h0, status_o[2:1]}, 32'h3);
		chk({31'h0, irq_o}, 32'h1);
		wb(esw_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0, rd);
		chk({29'h0, rd[2:0]}, 32'h4);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		sense.heat_crit <= 1'b0;
		sense.heat_on <= 1'b0;
		repeat (5) @(posedge clk_i);
		chk({30'h0, status_o[2:1]}, 32'h0);
		wb(esw_pkg::ADDR_CTRL, 1'b1, 32'h5, rd);
		sample(1);
		repeat (30) @(posedge clk_i);
		chk({31'h0, status_o[0]}, 32'h0);
		wait_bit(0, 1'b1, 60);
		repeat (100) @(posedge clk_i);
		chk({31'h0, status_o[4]}, 32'h0);
		wait_bit(4, 1'b1, 160);
		// second restart in mid-run
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(status_o, 32'h00002000);
		wb(esw_pkg::ADDR_CTRL, 1'b0, 32'h0, rd);
		chk(rd, esw_pkg::CTRL_RST);
		wb(esw_pkg::ADDR_IRQ_MASK, 1'b0, 32'h0, rd);
		chk(rd, 32'h0);
		// temperature fault alone, well before the no-value path could finish
		sense.virtual_temperature_violation <= 1'b1;
		repeat (150) @(posedge clk_i);
		chk({31'h0, status_o[4]}, 32'h0);
		wait_bit(4, 1'b1, 70);
		host.send(tw);
		chk({31'h0, tw[13]}, 32'h1);
		final_report();
	end
endmodule // tb_extended_status_word
